//--- rtl/aach_abort_and_compare.sv
// escape/abort handling, motor ramp-down and sequence comparison evaluator
`timescale 1ns/1ps
`include "aach_defs.svh"
module aach_abort_and_compare #(
   parameter int SPW = 16,
   parameter int TW = 24,
   parameter int DW = 32
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] rxChar,
   input wire logic rxValid,
   output logic [7:0] txChar,
   output logic txValid,
   input wire logic txReady,
   output logic lineClear,
   input wire logic abortTermCmd,
   input wire logic abortSeqCmd,
   input wire logic abortBusCmd,
   input wire logic motionStart,
   input wire logic [SPW-1:0] runSpeed,
   input wire logic [SPW-1:0] starting_speed,
   input wire logic [TW-1:0] decel_time,
   output logic [SPW-1:0] motorSpeed,
   output logic motorRunning,
   input wire logic seqStart,
   input wire logic seqEnd,
   output logic seqRunning,
   input wire logic dispStart,
   output logic dispActive,
   input wire logic [2:0] cmpOp,
   input wire logic signed [DW-1:0] cmpA,
   input wire logic signed [DW-1:0] cmpB,
   output logic cmpResult
);
   aach_pkg::aach_mot_t motState_ff, nxt_motState;
   aach_pkg::aach_tx_t txState_ff, nxt_txState;
   logic [SPW-1:0] speed_ff, nxt_speed;
   logic [TW-1:0] rampCnt_ff, nxt_rampCnt;
   logic [SPW-1:0] step_ff;
   logic seqRun_ff, dispAct_ff, cmp_ff;

   // character arriving from the terminal, same clock domain
   wire escHit = rxValid && (rxChar == `AACH_CH_ESC);
   wire abortAny = abortTermCmd || abortSeqCmd || abortBusCmd;
   wire stopReq = escHit || abortAny;
   // per-tick decrement spreads the drop over decel_time ticks; the step is
   // rounded up so that decel_time steps always land on the starting speed
   // span comes from the speed actually held, so a later runSpeed change cannot skew it
   wire [SPW-1:0] spanSpeed = (speed_ff > starting_speed) ? speed_ff - starting_speed : `AACH_SPEED_ZERO;
   // a zero decel_time would divide by zero; one tick is the shortest ramp
   wire [TW-1:0] safeTime = (decel_time == '0) ? `AACH_CNT_ONE : decel_time;
   // one spare bit keeps span plus time from wrapping before the divide
   wire [TW:0] stepNum = (TW+1)'(spanSpeed) + {1'b0, safeTime} - (TW+1)'(`AACH_CNT_ONE);
   wire [TW:0] stepQuot = stepNum / {1'b0, safeTime};
   wire [SPW-1:0] stepCalc = stepQuot[SPW-1:0];
   // compare the distance above the floor, not starting_speed + step, which could wrap
   wire [SPW-1:0] lowered = (spanSpeed > step_ff) ? speed_ff - step_ff : starting_speed;
   wire rampDone = (speed_ff <= starting_speed) || (rampCnt_ff == '0);
   wire runStop = (motState_ff == aach_pkg::MOT_RUN) && stopReq;

   // motor state: stop requests never cut speed at once, they ramp
   always_comb begin
      nxt_motState = motState_ff;
      nxt_speed = speed_ff;
      nxt_rampCnt = rampCnt_ff;
      case (motState_ff)
         aach_pkg::MOT_IDLE: begin
            // idle stop request leaves motion untouched
            if (motionStart && !stopReq) begin
               nxt_motState = aach_pkg::MOT_RUN;
               nxt_speed = runSpeed;
            end
         end
         aach_pkg::MOT_RUN: begin
            if (stopReq) begin
               nxt_motState = aach_pkg::MOT_RAMP;
               nxt_rampCnt = safeTime;
            end
         end
         aach_pkg::MOT_RAMP: begin
            // the counter only guards against a stalled ramp; the floor normally ends it
            if (rampDone) begin
               nxt_motState = aach_pkg::MOT_IDLE; // reached starting speed, stop fully
               nxt_speed = `AACH_SPEED_ZERO;
            end else begin
               nxt_rampCnt = rampCnt_ff - `AACH_CNT_ONE;
               nxt_speed = lowered;
            end
         end
         default: begin
            nxt_motState = aach_pkg::MOT_IDLE;
            nxt_speed = `AACH_SPEED_ZERO;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         motState_ff <= aach_pkg::MOT_IDLE;
         speed_ff <= `AACH_SPEED_ZERO;
         rampCnt_ff <= '0;
         step_ff <= '0;
      end else begin
         motState_ff <= nxt_motState;
         speed_ff <= nxt_speed;
         rampCnt_ff <= nxt_rampCnt;
         if (runStop) begin
            step_ff <= stepCalc;
         end
      end
   end

   // stop has priority over a start in the same cycle, so a late start cannot revive it
   wire seqClear = stopReq || seqEnd;
   wire dispClear = escHit; // abort on its own leaves the display running

   // stored-sequence running flag
   always_ff @(posedge mclk) begin
      if (rst) begin
         seqRun_ff <= 1'b0;
      end else if (seqClear) begin
         seqRun_ff <= 1'b0;
      end else if (seqStart) begin
         seqRun_ff <= 1'b1;
      end
   end

   // continuous display flag, cleared only by escape
   always_ff @(posedge mclk) begin
      if (rst) begin
         dispAct_ff <= 1'b0;
      end else if (dispClear) begin
         dispAct_ff <= 1'b0;
      end else if (dispStart) begin
         dispAct_ff <= 1'b1;
      end
   end

   // echo CR, LF, prompt after escape; a new escape mid-echo restarts it
   always_comb begin
      nxt_txState = txState_ff;
      // each echo char stands until the host takes it
      case (txState_ff)
         aach_pkg::TX_IDLE: begin
            if (escHit) begin
               nxt_txState = aach_pkg::TX_CR;
            end
         end
         aach_pkg::TX_CR: begin
            if (txReady) begin
               nxt_txState = aach_pkg::TX_LF;
            end
         end
         aach_pkg::TX_LF: begin
            if (txReady) begin
               nxt_txState = aach_pkg::TX_PROMPT;
            end
         end
         aach_pkg::TX_PROMPT: begin
            if (txReady) begin
               nxt_txState = aach_pkg::TX_IDLE;
            end
         end
         default: begin
            nxt_txState = aach_pkg::TX_IDLE;
         end
      endcase
      if (escHit && txState_ff != aach_pkg::TX_IDLE) begin
         nxt_txState = aach_pkg::TX_CR;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         txState_ff <= aach_pkg::TX_IDLE;
         lineClear <= 1'b0;
      end else begin
         txState_ff <= nxt_txState;
         lineClear <= escHit; // one pulse tells the line editor to drop its buffer
      end
   end

   assign txValid = (txState_ff != aach_pkg::TX_IDLE);
   assign txChar = (txState_ff == aach_pkg::TX_CR) ? `AACH_CH_CR :
                   (txState_ff == aach_pkg::TX_LF) ? `AACH_CH_LF :
                   (txState_ff == aach_pkg::TX_PROMPT) ? `AACH_CH_PROMPT : `AACH_CH_NUL;

   // comparison evaluator, signed so variables may go negative
   wire isEq = (cmpA == cmpB);
   wire isLt = (cmpA < cmpB);
   // the other four follow from equal and less-than, so one adder serves all
   wire isNe = !isEq;
   wire isLe = isLt || isEq;
   wire isGe = !isLt;
   wire isGt = !isLe;
   wire cmpNow = (cmpOp == 3'(aach_pkg::CMP_NE)) ? isNe :
                 (cmpOp == 3'(aach_pkg::CMP_LE)) ? isLe :
                 (cmpOp == 3'(aach_pkg::CMP_LT)) ? isLt :
                 (cmpOp == 3'(aach_pkg::CMP_EQ)) ? isEq :
                 (cmpOp == 3'(aach_pkg::CMP_EQ2)) ? isEq :
                 (cmpOp == 3'(aach_pkg::CMP_GE)) ? isGe :
                 (cmpOp == 3'(aach_pkg::CMP_GT)) ? isGt : 1'b0;

   always_ff @(posedge mclk) begin
      if (rst) begin
         cmp_ff <= 1'b0;
      end else begin
         cmp_ff <= cmpNow;
      end
   end

   assign cmpResult = cmp_ff;
   assign motorSpeed = speed_ff;
   assign motorRunning = (motState_ff != aach_pkg::MOT_IDLE);
   assign seqRunning = seqRun_ff;
   assign dispActive = dispAct_ff;
endmodule

//--- rtl/aach_defs.svh
// constants for the abort and compare handler
`ifndef AACH_DEFS_SVH
`define AACH_DEFS_SVH
`define AACH_CH_ESC 8'h1B
`define AACH_CH_CR 8'h0D
`define AACH_CH_LF 8'h0A
`define AACH_CH_PROMPT 8'h3E
`define AACH_CH_NUL 8'h00
`define AACH_SPEED_ZERO 16'h0000
`define AACH_CNT_ONE 24'h000001
`endif

//--- rtl/aach_pkg.sv
// types for the abort and compare handler
package aach_pkg;
   typedef enum logic [2:0] {
      CMP_NE,
      CMP_LE,
      CMP_LT,
      CMP_EQ,
      CMP_EQ2,
      CMP_GE,
      CMP_GT
   } aach_cmp_t;
   typedef enum logic [1:0] {
      MOT_IDLE,
      MOT_RUN,
      MOT_RAMP
   } aach_mot_t;
   typedef enum logic [1:0] {
      TX_IDLE,
      TX_CR,
      TX_LF,
      TX_PROMPT
   } aach_tx_t;
endpackage

//--- sim/aach_abort_and_compare_assertions.sv
// checker for the abort and compare handler
`timescale 1ns/1ps
module aach_checker #(parameter int SPW = 16, parameter int DW = 32) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] rxChar,
   input wire logic rxValid,
   input wire logic [7:0] txChar,
   input wire logic txValid,
   input wire logic txReady,
   input wire logic lineClear,
   input wire logic abortTermCmd,
   input wire logic abortSeqCmd,
   input wire logic abortBusCmd,
   input wire logic [SPW-1:0] starting_speed,
   input wire logic [SPW-1:0] motorSpeed,
   input wire logic motorRunning,
   input wire logic seqRunning,
   input wire logic dispActive,
   input wire logic [2:0] cmpOp,
   input wire logic signed [DW-1:0] cmpA,
   input wire logic signed [DW-1:0] cmpB,
   input wire logic cmpResult
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // any stop source, escape included
   wire logic esc = rxValid && rxChar == 8'h1B;
   wire logic stop = esc || abortTermCmd || abortSeqCmd || abortBusCmd;
   property p_clr; esc |=> lineClear && txValid && txChar == 8'h0D; endproperty
   a_clr: assert property (p_clr) else $error("escape not answered");
   property p_lf; txValid && txReady && txChar == 8'h0D && !esc |=> txValid && txChar == 8'h0A; endproperty
   a_lf: assert property (p_lf) else $error("LF does not follow CR");
   property p_disp; esc |=> !dispActive; endproperty
   a_disp: assert property (p_disp) else $error("display survives escape");
   property p_seq; stop |=> !seqRunning; endproperty
   a_seq: assert property (p_seq) else $error("sequence survives stop");
   property p_soft; stop && motorRunning && motorSpeed > starting_speed |=> motorRunning; endproperty
   a_soft: assert property (p_soft) else $error("abrupt halt");
   property p_floor; motorRunning && motorSpeed > starting_speed |=> motorRunning; endproperty
   a_floor: assert property (p_floor) else $error("stopped above starting speed");
   property p_end; stop && motorRunning |-> ##[1:300] !motorRunning && motorSpeed == '0; endproperty
   a_end: assert property (p_end) else $error("ramp never ends");
   property p_idle; stop && !motorRunning |=> !motorRunning; endproperty
   a_idle: assert property (p_idle) else $error("idle stop moved motor");
   property p_eq; cmpOp == 3'h3 || cmpOp == 3'h4 |=> cmpResult == ($past(cmpA) == $past(cmpB)); endproperty
   a_eq: assert property (p_eq) else $error("equality wrong");
   property p_gt; cmpOp == 3'h6 |=> cmpResult == ($past(cmpA) > $past(cmpB)); endproperty
   a_gt: assert property (p_gt) else $error("greater-than wrong");
   // main scenarios reached
   c_esc: cover property (esc && dispActive);
   c_run: cover property (stop && motorRunning);
   c_eq2: cover property (cmpOp == 3'h4 && cmpA == cmpB);
endmodule
bind aach_abort_and_compare aach_checker #(.SPW(SPW), .DW(DW)) u_aach_checker (
   .mclk(mclk), .rst(rst), .rxChar(rxChar), .rxValid(rxValid), .txChar(txChar), .txValid(txValid),
   .txReady(txReady), .lineClear(lineClear), .abortTermCmd(abortTermCmd), .abortSeqCmd(abortSeqCmd),
   .abortBusCmd(abortBusCmd), .starting_speed(starting_speed), .motorSpeed(motorSpeed),
   .motorRunning(motorRunning), .seqRunning(seqRunning), .dispActive(dispActive), .cmpOp(cmpOp),
   .cmpA(cmpA), .cmpB(cmpB), .cmpResult(cmpResult));

//--- sim/aach_host_model.sv
// host terminal taking echo chars with random stalls
`timescale 1ns/1ps
module aach_host_model (
   input wire logic mclk,
   input wire logic [7:0] txChar,
   input wire logic txValid,
   output logic txReady,
   output logic [23:0] gotLine
);
   initial begin
      txReady = 1'b0;
      gotLine = 24'h000000;
   end
   // keeps the last three chars; ready moves just after the edge so no race
   always @(posedge mclk) begin
      if (txValid && txReady) gotLine <= {gotLine[15:0], txChar};
      txReady <= #2 1'($urandom_range(1));
   end
endmodule

//--- sim/abort_and_compare_handler_bench.sv
// self-checking bench for the abort and compare handler
`timescale 1ns/1ps
module abort_and_compare_handler_bench;
   logic mclk = 1'b0, rst = 1'b1, rxValid = 1'b0, motionStart = 1'b0, seqStart = 1'b0, dispStart = 1'b0;
   logic [7:0] rxChar = 8'h00, txChar;
   logic [2:0] ab = 3'h0, cmpOp = 3'h0;
   logic [15:0] runSpeed = 16'h0064, starting_speed = 16'h0014, motorSpeed, lastSpeed;
   logic [23:0] decel_time = 24'h000008, gotLine;
   logic signed [31:0] cmpA = 32'h0, cmpB = 32'h0;
   logic txValid, txReady, lineClear, motorRunning, seqRunning, dispActive, cmpResult;
   int errors = 0, checks_done = 0, n;
   always #12.5 mclk = ~mclk;
   aach_abort_and_compare u_aach_abort_and_compare (
      .mclk(mclk), .rst(rst), .rxChar(rxChar), .rxValid(rxValid), .txChar(txChar), .txValid(txValid),
      .txReady(txReady), .lineClear(lineClear), .abortTermCmd(ab[0]), .abortSeqCmd(ab[1]), .abortBusCmd(ab[2]),
      .motionStart(motionStart), .runSpeed(runSpeed), .starting_speed(starting_speed), .decel_time(decel_time),
      .motorSpeed(motorSpeed), .motorRunning(motorRunning), .seqStart(seqStart), .seqEnd(1'b0),
      .seqRunning(seqRunning), .dispStart(dispStart), .dispActive(dispActive), .cmpOp(cmpOp), .cmpA(cmpA),
      .cmpB(cmpB), .cmpResult(cmpResult));
   aach_host_model u_aach_host_model (.mclk(mclk), .txChar(txChar), .txValid(txValid), .txReady(txReady),
      .gotLine(gotLine));
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic tick(int k = 1);
      repeat (k) @(posedge mclk);
      #2;
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   function automatic logic expCmp(logic [2:0] op, logic signed [31:0] a, logic signed [31:0] b);
      case (op)
         3'h0: return a != b;
         3'h1: return a <= b;
         3'h2: return a < b;
         3'h3, 3'h4: return a == b;
         3'h5: return a >= b;
         3'h6: return a > b;
         default: return 1'b0;
      endcase
   endfunction
   initial begin
      void'($urandom(32'h3995));
      tick(20);
      rst = 1'b0;
      // every op code; first pass with equal operands, then small signed randoms
      for (int i = 0; i < 48; i++) begin
         cmpOp = i[2:0];
         cmpA = $urandom_range(4) - 2;
         cmpB = (i < 8) ? cmpA : $urandom_range(4) - 2;
         tick();
         chk("cmpResult", cmpResult, expCmp(cmpOp, cmpA, cmpB));
      end
      // each abort source, then escape, against running motor, sequence, display
      for (int s = 0; s < 4; s++) begin
         runSpeed = 16'h0028 + 16'($urandom_range(200));
         {motionStart, seqStart, dispStart} = 3'h7;
         tick();
         {motionStart, seqStart, dispStart} = 3'h0;
         tick(3);
         chk("running", {seqRunning, motorRunning, motorSpeed}, {2'h3, runSpeed});
         if (s == 3) {rxValid, rxChar} = {1'b1, 8'h1B};
         else ab[s] = 1'b1;
         tick();
         {rxValid, ab} = 4'h0;
         chk("ramp", {motorRunning, seqRunning, dispActive, lineClear}, {2'h2, s != 3, s == 3});
         for (n = 0; n < 40 && motorRunning; n++) begin
            lastSpeed = motorSpeed;
            tick();
            if (motorRunning) chk("falling", motorSpeed < lastSpeed, 1'b1);
         end
         if (n == 40) begin
            errors++;
            close_out();
         end
         chk("floor", lastSpeed, starting_speed);
         chk("stopped", motorSpeed, 16'h0000);
         chk("ramp time", n > decel_time / 2 && n <= decel_time + 1, 1'b1);
         tick(12);
         if (s == 3) chk("echo", gotLine, 24'h0D0A3E);
      end
      // all stops while idle, a start beside them is ignored
      ab = 3'h7;
      {rxValid, rxChar} = {1'b1, 8'h1B};
      motionStart = 1'b1;
      tick();
      {ab, motionStart, rxValid} = 5'h00;
      tick();
      chk("idle", {motorRunning, motorSpeed, seqRunning}, 18'h00000);
      close_out();
   end
endmodule
